// ==== core/kbd_pkg.sv ====
// Constants shared by the keyboard matrix encoder
package kbd_pkg;
    // Host port offsets (status/data select is host address bit one)
    localparam logic [7:0] KEY_CHARACTER_OUT_OFS = 8'h90;
    localparam logic [7:0] KEY_FLAG_BYTE_OFS = 8'h92;
    // Flag byte field positions
    localparam int FLAG_OBF_BIT = 0;
    localparam int FLAG_IBF_BIT = 1;
    localparam int FLAG_LOCAL_BIT = 2;
    localparam int FLAG_CMD_BIT = 3;
    localparam logic [7:0] FLAG_RESET = 8'h00;
    localparam logic [7:0] CHAR_RESET = 8'h00;
    // Matrix geometry
    localparam int ROWS = 8;
    localparam int COLS = 8;
    localparam int FIFO_DEPTH = 8;
    // Modifier keys occupy the last row
    localparam logic [2:0] MOD_ROW = 3'h7;
    localparam int KEY_SHIFT = 56;
    localparam int KEY_CONTROL = 57;
    localparam int KEY_TYPEWRITER_LOCK = 58;
    localparam int KEY_REPEAT = 59;
    // Key indices with special meaning
    localparam logic [5:0] KEY_LETTER_L = 6'h0B;
    localparam logic [5:0] KEY_LETTER_O = 6'h0E;
    localparam logic [5:0] KEY_LAST_LETTER = 6'h19;
    localparam logic [5:0] KEY_FIRST_DIGIT = 6'h1A;
    localparam logic [5:0] KEY_LAST_DIGIT = 6'h23;
    localparam logic [5:0] KEY_TAB = 6'h24;
    localparam logic [5:0] KEY_CUR_LEFT = 6'h25;
    localparam logic [5:0] KEY_CUR_RIGHT = 6'h26;
    localparam logic [5:0] KEY_CUR_UP = 6'h27;
    localparam logic [5:0] KEY_CUR_DOWN = 6'h28;
    localparam logic [5:0] KEY_SPACE = 6'h29;
    localparam logic [5:0] KEY_RETURN = 6'h2A;
    localparam logic [5:0] KEY_FIRST_PUNCT = 6'h2B;
    // Scan timing: strobe is held this long before columns are taken
    localparam int STROBE_NS = 160;
    localparam int CLK_PERIOD_NS = 40;
    localparam int STROBE_CYCLES = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Repeat rate of ten codes per second
    localparam int REPEAT_PERIOD_MS = 100;
    localparam int CLK_HZ = 25000000;
    localparam int REPEAT_CYCLES = CLK_HZ / 1000 * REPEAT_PERIOD_MS;
    // Scan states
    typedef enum logic [2:0] {
        ST_ADDR = 3'b001,
        ST_STROBE = 3'b010,
        ST_SAMPLE = 3'b100
    } scan_state_e;
endpackage

// ==== core/keyboard_matrix_encoder.sv ====
// Keyboard matrix encoder: row scan, key coding, eight-entry stack, host read port
// What this block does
// - Scan an eight by eight matrix one row at a time, sampling all columns.
// - Drive row address with strobe off first, then strobe while holding it.
// - Eight column inputs; active column under a strobed row marks that key.
// - Shift held gives upper-case code, else lower-case subject to typewriter lock.
// - Control with a letter key gives the matching control character.
// - Typewriter lock off forces upper case on letters only.
// - Shift, control, lock and repeat alone produce no code.
// - Repeat held with a code key regenerates its code ten times a second.
// - Tab and cursor keys give the same codes as control plus a letter.
// - Overlapping ordinary keys each produce their own code when pressed.
// - Up to eight unread codes are stacked; further keys are dropped when full.
// - Read strobe low drives character when select low, flag byte when high.
// - Data lines only go from device to host; nothing is written.
// - Output buffer full flag, bit zero, is set when a code waits.
// - Bit two shows local mode; input full and command flags read zero.
// - Shift-control-L enters local mode, shift-control-O returns on-line.
// - Rear panel switch in local position also shows local mode.
// - Scanning runs on its own; host reads never stall it.
module keyboard_matrix_encoder
#(
    parameter int REPEAT_LIMIT = kbd_pkg::REPEAT_CYCLES
)
(
    // Clock, reset, enable
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic clk_en,
    // Matrix side
    output logic [3:0] row_address_outputs,
    output logic [1:0] row_strobe_outputs,
    input wire logic [7:0] column_inputs,
    input wire logic rear_panel_mode_switch,
    // Host side
    input wire logic keyboard_read_strobe_n,
    input wire logic buffer_select_input,
    output logic [7:0] host_data_out,
    output logic host_data_oe
);
    import kbd_pkg::*;

    // Synchronisers for all pin inputs
    logic [7:0] col_meta_reg, col_sync_reg;
    logic [2:0] pin_meta_reg, pin_sync_reg;
    always_ff @(posedge clk_sys or posedge rst)
        if (rst)
        begin
            col_meta_reg <= 8'h00;
            col_sync_reg <= 8'h00;
            pin_meta_reg <= 3'h1;
            pin_sync_reg <= 3'h1;
        end
        else if (clk_en)
        begin
            col_meta_reg <= column_inputs;
            col_sync_reg <= col_meta_reg;
            pin_meta_reg <= {rear_panel_mode_switch, buffer_select_input, keyboard_read_strobe_n};
            pin_sync_reg <= pin_meta_reg;
        end
    logic rd_n_s, sel_s, sw_s;
    assign rd_n_s = pin_sync_reg[0];
    assign sel_s = pin_sync_reg[1];
    assign sw_s = pin_sync_reg[2];

    // Scan sequencer; the strobe dwell also covers the two-stage column sync
    scan_state_e state_reg;
    logic [2:0] row_reg;
    logic [3:0] dwell_reg;
    always_ff @(posedge clk_sys or posedge rst)
        if (rst)
        begin
            state_reg <= ST_ADDR;
            row_reg <= 3'h0;
            dwell_reg <= 4'h0;
        end
        else if (clk_en)
        begin
            unique case (state_reg)
                ST_ADDR:
                    state_reg <= ST_STROBE;
                ST_STROBE:
                begin
                    dwell_reg <= dwell_reg + 4'h1;
                    if (dwell_reg == 4'(STROBE_CYCLES + 2))
                        state_reg <= ST_SAMPLE;
                end
                ST_SAMPLE:
                begin
                    dwell_reg <= 4'h0;
                    row_reg <= row_reg + 3'h1;
                    state_reg <= ST_ADDR;
                end
            endcase
        end
    always_ff @(posedge clk_sys or posedge rst)
        if (rst)
        begin
            row_address_outputs <= 4'h0;
            row_strobe_outputs <= 2'b00;
        end
        else if (clk_en)
        begin
            row_address_outputs <= {1'b0, row_reg};
            row_strobe_outputs <= {2{state_reg == ST_STROBE}};
        end

    // Key state memory and new-press detection
    logic [63:0] down_reg;
    logic [7:0] row_down, new_keys, pick;
    logic [2:0] pick_col;
    logic hit;
    assign row_down = down_reg[{row_reg, 3'h0} +: 8];
    assign new_keys = col_sync_reg & ~row_down;
    always_comb
    begin
        pick = 8'h00;
        pick_col = 3'h0;
        for (int c = COLS - 1; c >= 0; c--)
            if (new_keys[c])
            begin
                pick = 8'h01 << c;
                pick_col = 3'(c);
            end
    end
    assign hit = (state_reg == ST_SAMPLE) && (row_reg != MOD_ROW) && (pick != 8'h00);
    always_ff @(posedge clk_sys or posedge rst)
        if (rst)
            down_reg <= 64'h0;
        else if (clk_en && state_reg == ST_SAMPLE)
        begin
            // One new key per row pass; others are seen next pass so none is lost
            if (row_reg == MOD_ROW)
                down_reg[{row_reg, 3'h0} +: 8] <= col_sync_reg;
            else
                down_reg[{row_reg, 3'h0} +: 8] <= (row_down & col_sync_reg) | pick;
        end

    logic shift_k, ctrl_k, lock_k, rep_k;
    assign shift_k = down_reg[KEY_SHIFT];
    assign ctrl_k = down_reg[KEY_CONTROL];
    assign lock_k = down_reg[KEY_TYPEWRITER_LOCK];
    assign rep_k = down_reg[KEY_REPEAT];

    function automatic logic [7:0] key_code(input logic [5:0] k, input logic sh,
                                            input logic ct, input logic lk);
        logic [7:0] c;
        c = 8'h20;
        if (k <= KEY_LAST_LETTER)
        begin
            c = 8'h61 + {2'h0, k};
            if (sh || !lk)
                c = c & 8'hDF;
            if (ct)
                c = c & 8'h1F;
        end
        else if (k <= KEY_LAST_DIGIT)
        begin
            c = 8'h30 + {2'h0, k - KEY_FIRST_DIGIT};
            if (sh)
                c = c ^ 8'h10;
        end
        else
            case (k)
                KEY_TAB: c = 8'h09;
                KEY_CUR_LEFT: c = 8'h08;
                KEY_CUR_RIGHT: c = 8'h0C;
                KEY_CUR_UP: c = 8'h0B;
                KEY_CUR_DOWN: c = 8'h0A;
                KEY_SPACE: c = 8'h20;
                KEY_RETURN: c = 8'h0D;
                default: c = 8'h2B + {2'h0, k - KEY_FIRST_PUNCT};
            endcase
        return c;
    endfunction

    // Local/on-line selection from the keyboard
    logic [5:0] hit_key;
    logic mode_cmd, local_reg, local_flag;
    assign hit_key = {row_reg, pick_col};
    assign mode_cmd = hit && shift_k && ctrl_k && (hit_key == KEY_LETTER_L || hit_key == KEY_LETTER_O);
    always_ff @(posedge clk_sys or posedge rst)
        if (rst)
            local_reg <= 1'b0;
        else if (clk_en && mode_cmd)
            local_reg <= (hit_key == KEY_LETTER_L);
    assign local_flag = local_reg | sw_s;

    // Repeat timer on the most recent code key
    logic [5:0] last_reg;
    logic [21:0] rpt_cnt_reg;
    logic rpt_due, emit;
    logic [5:0] emit_key;
    assign rpt_due = rep_k && down_reg[last_reg] && (rpt_cnt_reg >= 22'(REPEAT_LIMIT - 1));
    assign emit = (hit && !mode_cmd) || (!hit && rpt_due);
    assign emit_key = hit ? hit_key : last_reg;
    always_ff @(posedge clk_sys or posedge rst)
        if (rst)
        begin
            last_reg <= 6'h0;
            rpt_cnt_reg <= 22'h0;
        end
        else if (clk_en)
        begin
            if (hit)
            begin
                last_reg <= hit_key;
                rpt_cnt_reg <= 22'h0;
            end
            else if (!rep_k || !down_reg[last_reg] || rpt_due)
                rpt_cnt_reg <= 22'h0;
            else
                rpt_cnt_reg <= rpt_cnt_reg + 22'h1;
        end

    // Eight-entry character stack
    logic [7:0] stack_mem [FIFO_DEPTH];
    logic [2:0] wr_ptr_reg, rd_ptr_reg;
    logic [3:0] count_reg;
    logic push, pop, obf_reg;
    logic [7:0] char_reg;
    assign push = emit && (count_reg != 4'(FIFO_DEPTH));
    assign pop = !obf_reg && (count_reg != 4'h0);
    always_ff @(posedge clk_sys)
        if (clk_en && push)
            stack_mem[wr_ptr_reg] <= key_code(emit_key, shift_k, ctrl_k, lock_k);
    always_ff @(posedge clk_sys or posedge rst)
        if (rst)
        begin
            wr_ptr_reg <= 3'h0;
            rd_ptr_reg <= 3'h0;
            count_reg <= 4'h0;
        end
        else if (clk_en)
        begin
            if (push)
                wr_ptr_reg <= wr_ptr_reg + 3'h1;
            if (pop)
                rd_ptr_reg <= rd_ptr_reg + 3'h1;
            count_reg <= count_reg + {3'h0, push} - {3'h0, pop};
        end

    // Output buffer and host read port
    logic rd_n_d_reg, read_done;
    assign read_done = rd_n_s && !rd_n_d_reg && !sel_s;
    always_ff @(posedge clk_sys or posedge rst)
        if (rst)
        begin
            obf_reg <= 1'b0;
            char_reg <= CHAR_RESET;
            rd_n_d_reg <= 1'b1;
        end
        else if (clk_en)
        begin
            rd_n_d_reg <= rd_n_s;
            if (pop)
            begin
                char_reg <= stack_mem[rd_ptr_reg];
                obf_reg <= 1'b1;
            end
            else if (read_done)
                obf_reg <= 1'b0;
        end

    logic [7:0] flag_byte;
    always_comb
    begin
        flag_byte = FLAG_RESET;
        flag_byte[FLAG_OBF_BIT] = obf_reg;
        flag_byte[FLAG_LOCAL_BIT] = local_flag;
    end
    // Read-only port: the strobe drives the output enable and, on a character read, clears the full flag; select steers the mux, never the scan
    always_ff @(posedge clk_sys or posedge rst)
        if (rst)
        begin
            host_data_out <= FLAG_RESET;
            host_data_oe <= 1'b0;
        end
        else if (clk_en)
        begin
            host_data_oe <= !rd_n_s;
            host_data_out <= sel_s ? flag_byte : char_reg;
        end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst || !clk_en);

    sequence s_row_done;
        state_reg == ST_SAMPLE;
    endsequence
    sequence s_next_addr;
        state_reg == ST_ADDR && row_reg == $past(row_reg) + 3'h1;
    endsequence
    property p_row_step;
        s_row_done |=> s_next_addr;
    endproperty
    a_row_step: assert property (p_row_step) else $error("row not advanced");
    property p_addr_stable;
        row_strobe_outputs == 2'b11 |-> $stable(row_address_outputs);
    endproperty
    a_addr_stable: assert property (p_addr_stable) else $error("address moved");
    property p_addr_first;
        $rose(row_strobe_outputs[0]) |-> $stable(row_address_outputs);
    endproperty
    a_addr_first: assert property (p_addr_first) else $error("strobe too early");
    property p_stack_bound;
        count_reg <= 4'(FIFO_DEPTH);
    endproperty
    a_stack_bound: assert property (p_stack_bound) else $error("stack overflow");
    property p_full_drop;
        count_reg == 4'(FIFO_DEPTH) && !pop |=> count_reg == 4'(FIFO_DEPTH);
    endproperty
    a_full_drop: assert property (p_full_drop) else $error("full stack grew");
    property p_load_next;
        !obf_reg && count_reg != 4'h0 |=> obf_reg && count_reg == $past(count_reg) - 4'h1
            + {3'h0, $past(push)};
    endproperty
    a_load_next: assert property (p_load_next) else $error("next code not loaded");
    property p_read_clear;
        read_done && obf_reg |=> !obf_reg;
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("flag not cleared");
    property p_flag_byte;
        !rd_n_s && sel_s |=> host_data_oe && host_data_out[0] == $past(obf_reg)
            && host_data_out[7:3] == 5'h00 && host_data_out[1] == 1'b0;
    endproperty
    a_flag_byte: assert property (p_flag_byte) else $error("bad flag byte");
    property p_local_sw;
        sw_s && !rd_n_s && sel_s |=> host_data_out[2];
    endproperty
    a_local_sw: assert property (p_local_sw) else $error("local not shown");
    property p_mod_silent;
        state_reg == ST_SAMPLE && row_reg == MOD_ROW && !rpt_due |-> !push;
    endproperty
    a_mod_silent: assert property (p_mod_silent) else $error("modifier made code");
endmodule

// ==== tb/host_model.sv ====
// Host controller model: reads the character and flag ports of the keyboard encoder
module host_model
(
    // Clock
    input wire logic clk_sys,
    // Device answer
    input wire logic [7:0] host_data_out,
    input wire logic host_data_oe,
    // Read control
    output logic keyboard_read_strobe_n,
    output logic buffer_select_input
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        keyboard_read_strobe_n = 1'b1;
        buffer_select_input = 1'b0;
    end

    // Only reads exist; the model never writes the data lines
    task automatic read_port(input logic [7:0] addr, input int hold, output logic [7:0] data,
        output logic ok);
        int n;
        n = 0;
        @(posedge clk_sys);
        buffer_select_input <= addr[1];
        keyboard_read_strobe_n <= 1'b0;
        @(posedge clk_sys);
        while (host_data_oe !== 1'b1 && n < 20)
        begin
            @(posedge clk_sys);
            n++;
        end
        ok = (n < 20);
        data = host_data_out;
        repeat (hold) @(posedge clk_sys);
        keyboard_read_strobe_n <= 1'b1;
        n = 0;
        while (host_data_oe !== 1'b0 && n < 20)
        begin
            @(posedge clk_sys);
            n++;
        end
        // Strobe stays high long enough for the synchroniser to see the gap
        repeat (4) @(posedge clk_sys);
    endtask
endmodule

// ==== tb/testbench.sv ====
// Self-checking bench for the keyboard matrix encoder
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import kbd_pkg::*;

    localparam int REP = 400;
    localparam logic [7:0] SPECIAL [7] = '{8'h09, 8'h08, 8'h0C, 8'h0B, 8'h0A, 8'h20, 8'h0D};
    localparam int SPEC_KEY [5] = '{36, 37, 38, 39, 40};
    localparam int SPEC_LETTER [5] = '{8, 7, 11, 10, 9};

    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic clk_en = 1'b1;
    logic [7:0] column_inputs = 8'h00;
    logic rear_panel_mode_switch = 1'b0;
    logic [3:0] row_address_outputs;
    logic [1:0] row_strobe_outputs;
    logic keyboard_read_strobe_n;
    logic buffer_select_input;
    logic [7:0] host_data_out;
    logic host_data_oe;
    logic [63:0] keys = 64'h0400_0000_0000_0000;
    logic [3:0] prev_addr = 4'h0;
    logic [1:0] prev_strobe = 2'h0;
    int seed = 32'h53B67601;
    int failures = 0;
    int comparisons = 0;
    int cycles = 0;
    int addr_changes = 0;

    always #20 clk_sys = ~clk_sys;

    keyboard_matrix_encoder #(.REPEAT_LIMIT(REP)) keyboard_matrix_encoder_i (
        .clk_sys(clk_sys), .rst(rst), .clk_en(clk_en),
        .row_address_outputs(row_address_outputs), .row_strobe_outputs(row_strobe_outputs),
        .column_inputs(column_inputs), .rear_panel_mode_switch(rear_panel_mode_switch),
        .keyboard_read_strobe_n(keyboard_read_strobe_n),
        .buffer_select_input(buffer_select_input),
        .host_data_out(host_data_out), .host_data_oe(host_data_oe));

    host_model host_model_i (
        .clk_sys(clk_sys), .host_data_out(host_data_out), .host_data_oe(host_data_oe),
        .keyboard_read_strobe_n(keyboard_read_strobe_n),
        .buffer_select_input(buffer_select_input));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
        comparisons++;
        if (seen !== exp)
        begin
            failures++;
            $display("[ERR] %0t %s: saw %h expected %h", $time, msg, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Unstrobed columns carry noise so that a scan reading them shows up
    always @(posedge clk_sys)
    begin
        cycles++;
        if (row_strobe_outputs == 2'b11)
            column_inputs <= keys[{row_address_outputs[2:0], 3'b000} +: 8];
        else
            column_inputs <= 8'($random(seed));
        if (!rst && row_strobe_outputs == 2'b11 && prev_strobe == 2'b11)
            check({4'h0, row_address_outputs}, {4'h0, prev_addr}, "address moved under strobe");
        if (row_address_outputs !== prev_addr)
            addr_changes++;
        prev_addr <= row_address_outputs;
        prev_strobe <= row_strobe_outputs;
        if (cycles == 40000)
        begin
            failures++;
            $display("[ERR] %0t run did not finish", $time);
            test_done();
        end
    end

    function automatic logic [7:0] exp_code(input int k, input logic sh, input logic ct,
        input logic lk);
        logic [7:0] c;
        if (k < 26)
        begin
            c = 8'h61 + 8'(k);
            if (sh || !lk)
                c = c - 8'h20;
            if (ct)
                c = c & 8'h1F;
        end
        else if (k < 36)
            c = (8'h30 + 8'(k - 26)) ^ (sh ? 8'h10 : 8'h00);
        else if (k < 43)
            c = SPECIAL[k - 36];
        else
            c = 8'h2B + 8'(k - 43);
        return c;
    endfunction

    task automatic scans(input int n);
        repeat (n * 72) @(posedge clk_sys);
    endtask

    task automatic type_key(input int k, input logic sh, input logic ct, input logic lk);
        keys[56] <= sh;
        keys[57] <= ct;
        keys[58] <= lk;
        scans(2);
        keys[k] <= 1'b1;
        scans(3);
        keys[k] <= 1'b0;
        scans(1);
        keys[57:56] <= 2'b00;
        scans(1);
    endtask

    task automatic rd(input logic [7:0] addr, output logic [7:0] data);
        logic ok;
        host_model_i.read_port(addr, 0, data, ok);
        check({7'h00, ok}, 8'h01, "read not answered");
    endtask

    task automatic expect_char(input logic [7:0] exp);
        logic [7:0] d;
        rd(KEY_FLAG_BYTE_OFS, d);
        check(d, 8'h01, "flag byte with a code waiting");
        rd(KEY_CHARACTER_OUT_OFS, d);
        check(d, exp, "character code");
    endtask

    initial
    begin
        logic [7:0] d;
        logic [7:0] c1;
        logic ok;
        int k;
        int n;
        logic sh;
        logic ct;
        logic lk;
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (3) @(posedge clk_sys);
        rd(KEY_FLAG_BYTE_OFS, d);
        check(d, FLAG_RESET, "flag byte after reset");
        rd(KEY_CHARACTER_OUT_OFS, d);
        check(d, CHAR_RESET, "character after reset");
        $display("test reset done");
        for (int m = KEY_SHIFT; m <= KEY_REPEAT; m++)
        begin
            keys[m] <= ~keys[m];
            scans(3);
            keys[m] <= (m == KEY_TYPEWRITER_LOCK);
            scans(2);
            rd(KEY_FLAG_BYTE_OFS, d);
            check(d, 8'h00, "modifier alone made a code");
        end
        $display("test modifiers done");
        repeat (12)
        begin
            k = {$random(seed)} % 56;
            {sh, ct, lk} = 3'($random(seed));
            if (k >= 26 || (sh && (k == 11 || k == 14)))
                ct = 1'b0;
            if (k >= 36)
                sh = 1'b0;
            type_key(k, sh, ct, lk);
            expect_char(exp_code(k, sh, ct, lk));
            rd(KEY_FLAG_BYTE_OFS, d);
            check(d, 8'h00, "full flag stayed after read");
        end
        $display("test random keys done");
        for (int i = 0; i < 5; i++)
        begin
            type_key(SPEC_KEY[i], 1'b0, 1'b0, 1'b1);
            rd(KEY_CHARACTER_OUT_OFS, c1);
            check(c1, exp_code(SPEC_KEY[i], 1'b0, 1'b0, 1'b1), "tab or cursor code");
            type_key(SPEC_LETTER[i], 1'b0, 1'b1, 1'b1);
            expect_char(c1);
        end
        $display("test tab and cursor done");
        keys[5] <= 1'b1;
        scans(3);
        keys[20] <= 1'b1;
        scans(3);
        keys[5] <= 1'b0;
        keys[20] <= 1'b0;
        scans(2);
        expect_char(exp_code(5, 1'b0, 1'b0, 1'b1));
        expect_char(exp_code(20, 1'b0, 1'b0, 1'b1));
        $display("test rollover done");
        for (int i = 0; i < 10; i++)
            type_key(i, 1'b0, 1'b0, 1'b1);
        for (int i = 0; i < 9; i++)
            expect_char(exp_code(i, 1'b0, 1'b0, 1'b1));
        rd(KEY_FLAG_BYTE_OFS, d);
        check(d, 8'h00, "keys beyond a full stack kept");
        $display("test full stack done");
        type_key(KEY_LETTER_L, 1'b1, 1'b1, 1'b1);
        rd(KEY_FLAG_BYTE_OFS, d);
        check(d, 8'h04, "local mode by keys");
        type_key(KEY_LETTER_O, 1'b1, 1'b1, 1'b1);
        rd(KEY_FLAG_BYTE_OFS, d);
        check(d, 8'h00, "on-line mode by keys");
        rear_panel_mode_switch <= 1'b1;
        repeat (5) @(posedge clk_sys);
        rd(KEY_FLAG_BYTE_OFS, d);
        check(d, 8'h04, "local mode by switch");
        rear_panel_mode_switch <= 1'b0;
        repeat (5) @(posedge clk_sys);
        rd(KEY_FLAG_BYTE_OFS, d);
        check(d, 8'h00, "switch back on-line");
        $display("test local mode done");
        keys[KEY_REPEAT] <= 1'b1;
        scans(1);
        keys[0] <= 1'b1;
        repeat (2400) @(posedge clk_sys);
        keys[0] <= 1'b0;
        keys[KEY_REPEAT] <= 1'b0;
        scans(2);
        n = 0;
        rd(KEY_FLAG_BYTE_OFS, d);
        while (d[FLAG_OBF_BIT] === 1'b1 && n < 12)
        begin
            rd(KEY_CHARACTER_OUT_OFS, d);
            check(d, 8'h61, "repeated code");
            n++;
            rd(KEY_FLAG_BYTE_OFS, d);
        end
        // About one code per REP cycles while held, the first one at the press
        check({7'h00, (n >= 5 && n <= 7)}, 8'h01, "repeat count");
        $display("test repeat done");
        k = addr_changes;
        host_model_i.read_port(KEY_FLAG_BYTE_OFS, 200, d, ok);
        check({7'h00, ok}, 8'h01, "long read not answered");
        check(d, 8'h00, "flag byte during long read");
        check({7'h00, (addr_changes > k + 10)}, 8'h01, "scan stalled by read");
        $display("test scan during read done");
        test_done();
    end
endmodule
